// ===== bench/uedm_bm_model.sv
`timescale 1ns/1ps
module uedm_bm_model (
  input  wire logic [1:0] ep_in,
  input  wire logic       dir_in,
  input  wire logic       go_in,
  input  wire logic       force_in,
  input  wire logic       service_ok_in,
  output logic      [1:0] bm_ep_out,
  output logic            bm_dir_out,
  output logic            bm_done_out
);
  // Endpoint select held as a level
  assign bm_ep_out   = ep_in;
  assign bm_dir_out  = dir_in;
  // Completes only on enabled endpoints unless a fault is commanded
  assign bm_done_out = go_in & (service_ok_in | force_in);
endmodule

// ===== bench/uedm_endpoint_map_props.sv
`timescale 1ns/1ps
module uedm_endpoint_map_props (
  input wire logic        CLK_SYS_IN,
  input wire logic        RESET_IN,
  input wire logic        MCU_RD_IN,
  input wire logic [15:0] MCU_ADDR_IN,
  input wire logic [7:0]  MCU_RDATA_OUT,
  input wire logic        MCU_RVALID_OUT,
  input wire logic [1:0]  BM_EP_IN,
  input wire logic        BM_DIR_IN_IN,
  input wire logic        BM_DONE_IN,
  input wire logic        BM_DATA_TOGGLE_OUT,
  input wire logic        BM_USE_Y_OUT,
  input wire logic [10:0] BM_START_ADDR_OUT,
  input wire logic        BM_XFER_INT_OUT
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);
  AST_RD_ANSWER: assert property (MCU_RD_IN |=> MCU_RVALID_OUT)
    else $error("read not answered");
  AST_IDLE_ZERO: assert property (!MCU_RVALID_OUT |-> MCU_RDATA_OUT == 8'h00)
    else $error("read data not zero while idle");
  AST_HOLE_ZERO: assert property (
    MCU_RD_IN && MCU_ADDR_IN inside {[16'hff84:16'hfffb]} |=> MCU_RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  AST_INT_CAUSE: assert property (BM_XFER_INT_OUT |-> $past(BM_DONE_IN))
    else $error("interrupt without completion");
  AST_ALIGN: assert property (BM_START_ADDR_OUT[2:0] == 3'h0)
    else $error("start address low bits not zero");
  AST_EP0_OUT: assert property (
    BM_EP_IN == 2'h0 && !BM_DIR_IN_IN |=> BM_START_ADDR_OUT == 11'h6f0)
    else $error("endpoint 0 output buffer address wrong");
  AST_EP0_X: assert property (BM_EP_IN == 2'h0 |=> !BM_USE_Y_OUT)
    else $error("endpoint 0 uses second buffer");
  AST_Y_TOGGLE: assert property (BM_USE_Y_OUT |-> BM_DATA_TOGGLE_OUT)
    else $error("second buffer without toggle");
endmodule
bind uedm_endpoint_map uedm_endpoint_map_props u_props (
  .CLK_SYS_IN(CLK_SYS_IN), .RESET_IN(RESET_IN), .MCU_RD_IN(MCU_RD_IN),
  .MCU_ADDR_IN(MCU_ADDR_IN), .MCU_RDATA_OUT(MCU_RDATA_OUT), .MCU_RVALID_OUT(MCU_RVALID_OUT),
  .BM_EP_IN(BM_EP_IN), .BM_DIR_IN_IN(BM_DIR_IN_IN), .BM_DONE_IN(BM_DONE_IN),
  .BM_DATA_TOGGLE_OUT(BM_DATA_TOGGLE_OUT), .BM_USE_Y_OUT(BM_USE_Y_OUT),
  .BM_START_ADDR_OUT(BM_START_ADDR_OUT), .BM_XFER_INT_OUT(BM_XFER_INT_OUT));

// ===== bench/uedm_endpoint_map_tb.sv
`timescale 1ns/1ps
module uedm_endpoint_map_tb;
  logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, dir = 1'b0, go = 1'b0;
  logic        frc = 1'b0, own = 1'b0, ssent = 1'b0, mwr = 1'b0;
  logic        ok, tog, usey, stall, owned, xint, rvalid, bdir, bdone;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, mwdata = 8'h00, rdata, mrdata, fa, mask, ctl;
  logic [1:0]  ep = 2'h0, bep;
  logic [6:0]  cnt = 7'h00, bcount, size;
  logic [10:0] maddr = 11'h000, start;
  int          n_mismatch = 0, n_compared = 0;
  always #5 clk = ~clk;
  uedm_endpoint_map dut (
    .CLK_SYS_IN(clk), .RESET_IN(rst), .MCU_ADDR_IN(addr), .MCU_RD_IN(rd),
    .MCU_WR_IN(wr), .MCU_WDATA_IN(wdata), .MCU_RDATA_OUT(rdata), .MCU_RVALID_OUT(rvalid),
    .BM_EP_IN(bep), .BM_DIR_IN_IN(bdir), .BM_DONE_IN(bdone), .BM_DONE_COUNT_IN(cnt),
    .BM_DONE_OWNED_IN(own), .BM_STALL_SENT_IN(ssent), .BM_MEM_ADDR_IN(maddr),
    .BM_MEM_WR_IN(mwr), .BM_MEM_WDATA_IN(mwdata), .BM_MEM_RDATA_OUT(mrdata),
    .BM_SERVICE_OK_OUT(ok), .BM_DATA_TOGGLE_OUT(tog), .BM_USE_Y_OUT(usey),
    .BM_STALL_OUT(stall), .BM_START_ADDR_OUT(start), .BM_COUNT_OUT(bcount),
    .BM_BUFFER_OWNED_OUT(owned), .BM_SIZE_OUT(size), .BM_XFER_INT_OUT(xint),
    .FUNCTION_ADDR_OUT(fa), .USB_INT_MASK_OUT(mask), .USB_CONTROL_OUT(ctl));
  uedm_bm_model bm (.ep_in(ep), .dir_in(dir), .go_in(go), .force_in(frc), .service_ok_in(ok),
    .bm_ep_out(bep), .bm_dir_out(bdir), .bm_done_out(bdone));
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd8(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk("read valid", 16'h0001, {15'h0, rvalid});
    chk("read data", {8'h00, e}, {8'h00, rdata});
  endtask
  task automatic sel(input logic [1:0] n, input logic d);
    @(negedge clk);
    ep = n;
    dir = d;
    repeat (3) @(negedge clk);
  endtask
  task automatic done(input logic [6:0] c, input logic o, input logic f, input logic ei);
    @(negedge clk);
    cnt = c;
    own = o;
    frc = f;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    frc = 1'b0;
    chk("completion interrupt", {15'h0, ei}, {15'h0, xint});
    repeat (3) @(negedge clk);
  endtask
  task automatic t_regs();
    logic [15:0] a [8] = '{16'hff80, 16'hff81, 16'hff82, 16'hff83,
                           16'hfffc, 16'hfffd, 16'hfffe, 16'hffff};
    foreach (a[i]) rd8(a[i], 8'h00);
    foreach (a[i]) wr8(a[i], {4'ha, i[3:0]});
    foreach (a[i]) rd8(a[i], {4'ha, i[3:0]});
    chk("control copy", 16'h00a4, {8'h00, ctl});
    chk("mask copy", 16'h00a5, {8'h00, mask});
    chk("address copy", 16'h00a7, {8'h00, fa});
    wr8(16'hff84, 8'h5a);
    rd8(16'hff84, 8'h00);
    rd8(16'hff90, 8'h00);
  endtask
  task automatic t_descs();
    logic [15:0] b;
    logic [7:0]  base;
    for (int d = 0; d < 2; d++) begin
      for (int n = 1; n < 4; n++) begin
        b = (d == 1 ? 16'hff40 : 16'hff00) + 16'(n * 8);
        base = 8'(32 + n + 4 * d);
        wr8(b + 16'h1, base);
        wr8(b + 16'h2, 8'h03);
        wr8(b + 16'h3, 8'hff);
        wr8(b + 16'h4, 8'hff);
        wr8(b + 16'h7, 8'h40);
        wr8(b, 8'h80);
        sel(2'(n), d[0]);
        chk("service enable", 16'h1, {15'h0, ok});
        chk("start", {5'h0, base, 3'h0}, {5'h0, start});
        chk("count", 16'h3, {9'h0, bcount});
        chk("size", 16'h40, {9'h0, size});
      end
    end
  endtask
  task automatic t_done();
    wr8(16'hff0d, 8'h30);
    wr8(16'hff0e, 8'h00);
    wr8(16'hff08, 8'h94);
    sel(2'h1, 1'b0);
    done(7'h05, 1'b1, 1'b0, 1'b1);
    chk("toggle", 16'h1, {15'h0, tog});
    chk("use y", 16'h1, {15'h0, usey});
    chk("start y", 16'h0180, {5'h0, start});
    rd8(16'hff0a, 8'h85);
    rd8(16'hff09, 8'h21);
    done(7'h40, 1'b0, 1'b0, 1'b1);
    rd8(16'hff0e, 8'h40);
    chk("start x", 16'h0108, {5'h0, start});
    chk("count", 16'h5, {9'h0, bcount});
    chk("owned", 16'h1, {15'h0, owned});
    wr8(16'hff08, 8'h80);
    sel(2'h1, 1'b0);
    done(7'h01, 1'b0, 1'b0, 1'b0);
    wr8(16'hff08, 8'h14);
    sel(2'h1, 1'b0);
    done(7'h02, 1'b1, 1'b1, 1'b0);
    rd8(16'hff0a, 8'h01);
    rd8(16'hff08, 8'h14);
  endtask
  task automatic t_stall();
    wr8(16'hff08, 8'h88);
    sel(2'h1, 1'b0);
    chk("stall", 16'h1, {15'h0, stall});
    @(negedge clk);
    ssent = 1'b1;
    @(negedge clk);
    ssent = 1'b0;
    repeat (2) @(negedge clk);
    chk("stall held", 16'h1, {15'h0, stall});
    wr8(16'hff08, 8'h80);
    sel(2'h1, 1'b0);
    chk("stall cleared", 16'h0, {15'h0, stall});
    wr8(16'hff48, 8'h88);
    sel(2'h1, 1'b1);
    chk("in stall", 16'h1, {15'h0, stall});
    @(negedge clk);
    ssent = 1'b1;
    @(negedge clk);
    ssent = 1'b0;
    repeat (2) @(negedge clk);
    chk("in stall sent", 16'h0, {15'h0, stall});
    rd8(16'hff48, 8'h80);
  endtask
  task automatic t_buf();
    sel(2'h0, 1'b1);
    chk("ep0 in start", 16'h06f8, {5'h0, start});
    chk("ep0 size", 16'h8, {9'h0, size});
    done(7'h08, 1'b0, 1'b0, 1'b0);
    chk("ep0 use y", 16'h0, {15'h0, usey});
    rd8(16'hff81, 8'h08);
    rd8(16'hff80, 8'h80);
    @(negedge clk);
    maddr = 11'h580;
    mwdata = 8'h3c;
    mwr = 1'b1;
    @(negedge clk);
    maddr = 11'h6f0;
    mwdata = 8'hc3;
    @(negedge clk);
    mwr = 1'b0;
    rd8(16'hfd80, 8'h3c);
    rd8(16'hfef0, 8'hc3);
    wr8(16'hfeef, 8'h77);
    maddr = 11'h6ef;
    @(negedge clk);
    chk("buffer read", 16'h0077, {8'h00, mrdata});
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_descs();
    t_done();
    t_stall();
    t_buf();
    final_report();
  end
  initial begin
    #500000;
    n_mismatch++;
    final_report();
  end
endmodule

// ===== rtl/uedm_endpoint_map.sv
`timescale 1ns/1ps
// What this block does
// - Three in, three out endpoint descriptors provided
// - Descriptors 8 bytes at FF48/FF08 steps
// - Packet buffer pool spans FD80 to FEEF
// - Fixed endpoint 0 buffers and setup block
// - Descriptor byte layout: config, bases, counts, size
// - Endpoint 0 registers at FF80 to FF83
// - USB registers mapped at FFFC to FFFF
// - Config bit 7 gates buffer manager service
// - Config bit 5 holds data toggle state
// - Config bit 4 selects single or dual buffering on endpoints 1 to 3
// - Output stall bit holds until firmware clears
// - Config bit 2 enables completion interrupt
// - Base field plus three zeros gives address
// - Completion never alters base address field
// - Byte counts are 7 bits, 0 to 64
// - Count bit 7 flags buffer owned, NAK
module uedm_endpoint_map (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RESET_IN,
  input  wire logic [15:0] MCU_ADDR_IN,
  input  wire logic        MCU_RD_IN,
  input  wire logic        MCU_WR_IN,
  input  wire logic [7:0]  MCU_WDATA_IN,
  output logic      [7:0]  MCU_RDATA_OUT,
  output logic             MCU_RVALID_OUT,
  input  wire logic [1:0]  BM_EP_IN,
  input  wire logic        BM_DIR_IN_IN,
  input  wire logic        BM_DONE_IN,
  input  wire logic [6:0]  BM_DONE_COUNT_IN,
  input  wire logic        BM_DONE_OWNED_IN,
  input  wire logic        BM_STALL_SENT_IN,
  input  wire logic [10:0] BM_MEM_ADDR_IN,
  input  wire logic        BM_MEM_WR_IN,
  input  wire logic [7:0]  BM_MEM_WDATA_IN,
  output logic      [7:0]  BM_MEM_RDATA_OUT,
  output logic             BM_SERVICE_OK_OUT,
  output logic             BM_DATA_TOGGLE_OUT,
  output logic             BM_USE_Y_OUT,
  output logic             BM_STALL_OUT,
  output logic      [10:0] BM_START_ADDR_OUT,
  output logic      [6:0]  BM_COUNT_OUT,
  output logic             BM_BUFFER_OWNED_OUT,
  output logic      [6:0]  BM_SIZE_OUT,
  output logic             BM_XFER_INT_OUT,
  output logic      [7:0]  FUNCTION_ADDR_OUT,
  output logic      [7:0]  USB_INT_MASK_OUT,
  output logic      [7:0]  USB_CONTROL_OUT
);

  logic [7:0]  mem_q [0:uedm_pkg::RAM_BYTES-1];
  logic [7:0]  in_ep0_config_q, in_ep0_config_d;
  logic [7:0]  in_ep0_count_q, in_ep0_count_d;
  logic [7:0]  out_ep0_config_q, out_ep0_config_d;
  logic [7:0]  out_ep0_count_q, out_ep0_count_d;
  logic [7:0]  func_addr_q, func_addr_d;
  logic [7:0]  usb_status_q, usb_status_d;
  logic [7:0]  usb_mask_q, usb_mask_d;
  logic [7:0]  usb_ctl_q, usb_ctl_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d;
  logic [7:0]  bm_rdata_q, bm_rdata_d;
  logic        svc_q, svc_d;
  logic        tog_q, tog_d;
  logic        usey_q, usey_d;
  logic        stall_q, stall_d;
  logic [10:0] start_q, start_d;
  logic [6:0]  cnt_q, cnt_d;
  logic        own_q, own_d;
  logic [6:0]  size_q, size_d;
  logic        xint_q, xint_d;

  logic        mcu_in_ram;
  logic [8:0]  mcu_idx;
  logic [8:0]  bm_idx;
  logic [15:0] bm_xaddr;
  logic [15:0] desc_base;
  logic [8:0]  desc_idx;
  logic [8:0]  cfg_idx;
  logic [8:0]  cnt_idx;
  logic [7:0]  cur_cfg;
  logic [7:0]  cur_xbase;
  logic [7:0]  cur_ybase;
  logic [7:0]  cur_xcnt;
  logic [7:0]  cur_ycnt;
  logic [7:0]  cur_size;
  logic        ep0_sel;
  logic        sel_y;
  logic        done_ok;
  logic [7:0]  new_cfg;
  logic [7:0]  new_cnt;

  // Shared RAM decode; endpoint 0 regs live outside it
  assign mcu_in_ram = (MCU_ADDR_IN >= uedm_pkg::RAM_BASE) &&
                      (MCU_ADDR_IN <= uedm_pkg::RAM_LAST);
  assign mcu_idx    = 9'(MCU_ADDR_IN - uedm_pkg::RAM_BASE);
  assign bm_xaddr   = uedm_pkg::BUF_SPACE_BASE + {5'h00, BM_MEM_ADDR_IN};
  assign bm_idx     = 9'(bm_xaddr - uedm_pkg::RAM_BASE);

  // Descriptor of endpoints 1 to 3 selected by the buffer manager
  assign desc_base = BM_DIR_IN_IN ? uedm_pkg::IN_DESC_BASE : uedm_pkg::OUT_DESC_BASE;
  assign desc_idx  = 9'(desc_base + 16'(BM_EP_IN) * 16'(uedm_pkg::DESC_BYTES)
                        - uedm_pkg::RAM_BASE);
  assign ep0_sel   = (BM_EP_IN == 2'h0);

  always_comb begin
    cfg_idx = desc_idx + 9'(uedm_pkg::OFS_CONFIG);
    if (ep0_sel) begin
      cur_cfg   = BM_DIR_IN_IN ? in_ep0_config_q : out_ep0_config_q;
      cur_xcnt  = BM_DIR_IN_IN ? in_ep0_count_q : out_ep0_count_q;
      cur_xbase = BM_DIR_IN_IN ? uedm_pkg::IN_EP0_BUF[10:3]
                               : uedm_pkg::OUT_EP0_BUF[10:3];
      cur_ybase = cur_xbase;
      cur_ycnt  = cur_xcnt;
      cur_size  = 8'(uedm_pkg::DESC_BYTES);
    end else begin
      cur_cfg   = mem_q[cfg_idx];
      cur_xbase = mem_q[desc_idx + 9'(uedm_pkg::OFS_X_BASE)];
      cur_xcnt  = mem_q[desc_idx + 9'(uedm_pkg::OFS_X_COUNT)];
      cur_ybase = mem_q[desc_idx + 9'(uedm_pkg::OFS_Y_BASE)];
      cur_ycnt  = mem_q[desc_idx + 9'(uedm_pkg::OFS_Y_COUNT)];
      cur_size  = mem_q[desc_idx + 9'(uedm_pkg::OFS_XY_SIZE)];
    end
  end

  // Y buffer only when dual buffering is on and toggle says so
  assign sel_y   = ~ep0_sel & cur_cfg[uedm_pkg::BIT_DUAL_BUFFER_ENABLE]
                   & cur_cfg[uedm_pkg::BIT_DATA_TOGGLE_STATE];
  assign cnt_idx = desc_idx + (sel_y ? 9'(uedm_pkg::OFS_Y_COUNT)
                                     : 9'(uedm_pkg::OFS_X_COUNT));
  // Completions on a disabled endpoint are dropped
  assign done_ok = BM_DONE_IN & cur_cfg[uedm_pkg::BIT_MANAGER_USE_ENABLE];

  always_comb begin
    new_cfg = cur_cfg;
    if (done_ok) begin
      new_cfg[uedm_pkg::BIT_DATA_TOGGLE_STATE] =
        ~cur_cfg[uedm_pkg::BIT_DATA_TOGGLE_STATE];
    end
    if (BM_STALL_SENT_IN && BM_DIR_IN_IN) begin
      new_cfg[uedm_pkg::BIT_STALL] = 1'b0;
    end
    new_cnt = {BM_DONE_OWNED_IN, BM_DONE_COUNT_IN};
  end

  // Shared RAM; hardware updates land after firmware writes so they win
  always_ff @(posedge CLK_SYS_IN) begin
    if (MCU_WR_IN && mcu_in_ram) begin
      mem_q[mcu_idx] <= MCU_WDATA_IN;
    end
    if (BM_MEM_WR_IN) begin
      mem_q[bm_idx] <= BM_MEM_WDATA_IN;
    end
    if (!ep0_sel && (done_ok || (BM_STALL_SENT_IN && BM_DIR_IN_IN))) begin
      mem_q[cfg_idx] <= new_cfg;
    end
    if (!ep0_sel && done_ok) begin
      mem_q[cnt_idx] <= new_cnt;
    end
  end

  // Memory-mapped registers
  always_comb begin
    in_ep0_config_d  = in_ep0_config_q;
    in_ep0_count_d   = in_ep0_count_q;
    out_ep0_config_d = out_ep0_config_q;
    out_ep0_count_d  = out_ep0_count_q;
    func_addr_d      = func_addr_q;
    usb_status_d     = usb_status_q;
    usb_mask_d       = usb_mask_q;
    usb_ctl_d        = usb_ctl_q;
    if (MCU_WR_IN) begin
      unique case (MCU_ADDR_IN)
        uedm_pkg::ADDR_IN_EP0_CONFIG:  in_ep0_config_d  = MCU_WDATA_IN;
        uedm_pkg::ADDR_IN_EP0_COUNT:   in_ep0_count_d   = MCU_WDATA_IN;
        uedm_pkg::ADDR_OUT_EP0_CONFIG: out_ep0_config_d = MCU_WDATA_IN;
        uedm_pkg::ADDR_OUT_EP0_COUNT:  out_ep0_count_d  = MCU_WDATA_IN;
        uedm_pkg::ADDR_FUNCTION_ADDR:  func_addr_d      = MCU_WDATA_IN;
        uedm_pkg::ADDR_USB_STATUS:     usb_status_d     = MCU_WDATA_IN;
        uedm_pkg::ADDR_USB_INT_MASK:   usb_mask_d       = MCU_WDATA_IN;
        uedm_pkg::ADDR_USB_CONTROL:    usb_ctl_d        = MCU_WDATA_IN;
        default: ;
      endcase
    end
    if (ep0_sel && (done_ok || (BM_STALL_SENT_IN && BM_DIR_IN_IN))) begin
      if (BM_DIR_IN_IN) begin
        in_ep0_config_d = new_cfg;
      end else begin
        out_ep0_config_d = new_cfg;
      end
    end
    if (ep0_sel && done_ok) begin
      if (BM_DIR_IN_IN) begin
        in_ep0_count_d = new_cnt;
      end else begin
        out_ep0_count_d = new_cnt;
      end
    end
  end

  // Read path and buffer manager lookup
  always_comb begin
    rvalid_d = MCU_RD_IN;
    rdata_d  = 8'h00;
    if (MCU_RD_IN) begin
      if (mcu_in_ram) begin
        rdata_d = mem_q[mcu_idx];
      end else begin
        unique case (MCU_ADDR_IN)
          uedm_pkg::ADDR_IN_EP0_CONFIG:  rdata_d = in_ep0_config_q;
          uedm_pkg::ADDR_IN_EP0_COUNT:   rdata_d = in_ep0_count_q;
          uedm_pkg::ADDR_OUT_EP0_CONFIG: rdata_d = out_ep0_config_q;
          uedm_pkg::ADDR_OUT_EP0_COUNT:  rdata_d = out_ep0_count_q;
          uedm_pkg::ADDR_FUNCTION_ADDR:  rdata_d = func_addr_q;
          uedm_pkg::ADDR_USB_STATUS:     rdata_d = usb_status_q;
          uedm_pkg::ADDR_USB_INT_MASK:   rdata_d = usb_mask_q;
          uedm_pkg::ADDR_USB_CONTROL:    rdata_d = usb_ctl_q;
          default:                       rdata_d = 8'h00;
        endcase
      end
    end
    bm_rdata_d = mem_q[bm_idx];
    svc_d      = cur_cfg[uedm_pkg::BIT_MANAGER_USE_ENABLE];
    tog_d      = cur_cfg[uedm_pkg::BIT_DATA_TOGGLE_STATE];
    usey_d     = sel_y;
    stall_d    = cur_cfg[uedm_pkg::BIT_STALL];
    start_d    = {(sel_y ? cur_ybase : cur_xbase), 3'h0};
    cnt_d      = sel_y ? cur_ycnt[6:0] : cur_xcnt[6:0];
    own_d      = sel_y ? cur_ycnt[uedm_pkg::BIT_BUFFER_OWNED]
                       : cur_xcnt[uedm_pkg::BIT_BUFFER_OWNED];
    size_d     = cur_size[6:0];
    xint_d     = done_ok & cur_cfg[uedm_pkg::BIT_COMPLETION_INT_EN];
  end

  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      in_ep0_config_q  <= uedm_pkg::RESET_EP0_CONFIG;
      in_ep0_count_q   <= uedm_pkg::RESET_EP0_COUNT;
      out_ep0_config_q <= uedm_pkg::RESET_EP0_CONFIG;
      out_ep0_count_q  <= uedm_pkg::RESET_EP0_COUNT;
      func_addr_q      <= uedm_pkg::RESET_USB_REG;
      usb_status_q     <= uedm_pkg::RESET_USB_REG;
      usb_mask_q       <= uedm_pkg::RESET_USB_REG;
      usb_ctl_q        <= uedm_pkg::RESET_USB_REG;
      rdata_q          <= 8'h00;
      rvalid_q         <= 1'b0;
      bm_rdata_q       <= 8'h00;
      svc_q            <= 1'b0;
      tog_q            <= 1'b0;
      usey_q           <= 1'b0;
      stall_q          <= 1'b0;
      start_q          <= 11'h000;
      cnt_q            <= 7'h00;
      own_q            <= 1'b0;
      size_q           <= 7'h00;
      xint_q           <= 1'b0;
    end else begin
      in_ep0_config_q  <= in_ep0_config_d;
      in_ep0_count_q   <= in_ep0_count_d;
      out_ep0_config_q <= out_ep0_config_d;
      out_ep0_count_q  <= out_ep0_count_d;
      func_addr_q      <= func_addr_d;
      usb_status_q     <= usb_status_d;
      usb_mask_q       <= usb_mask_d;
      usb_ctl_q        <= usb_ctl_d;
      rdata_q          <= rdata_d;
      rvalid_q         <= rvalid_d;
      bm_rdata_q       <= bm_rdata_d;
      svc_q            <= svc_d;
      tog_q            <= tog_d;
      usey_q           <= usey_d;
      stall_q          <= stall_d;
      start_q          <= start_d;
      cnt_q            <= cnt_d;
      own_q            <= own_d;
      size_q           <= size_d;
      xint_q           <= xint_d;
    end
  end

  assign MCU_RDATA_OUT       = rdata_q;
  assign MCU_RVALID_OUT      = rvalid_q;
  assign BM_MEM_RDATA_OUT    = bm_rdata_q;
  assign BM_SERVICE_OK_OUT   = svc_q;
  assign BM_DATA_TOGGLE_OUT  = tog_q;
  assign BM_USE_Y_OUT        = usey_q;
  assign BM_STALL_OUT        = stall_q;
  assign BM_START_ADDR_OUT   = start_q;
  assign BM_COUNT_OUT        = cnt_q;
  assign BM_BUFFER_OWNED_OUT = own_q;
  assign BM_SIZE_OUT         = size_q;
  assign BM_XFER_INT_OUT     = xint_q;
  assign FUNCTION_ADDR_OUT   = func_addr_q;
  assign USB_INT_MASK_OUT    = usb_mask_q;
  assign USB_CONTROL_OUT     = usb_ctl_q;

endmodule

// ===== rtl/uedm_pkg.sv
package uedm_pkg;
  // Shared RAM window and buffer regions (XDATA byte addresses)
  localparam logic [15:0] RAM_BASE       = 16'hfd80;
  localparam logic [15:0] RAM_LAST       = 16'hff7f;
  localparam int          RAM_BYTES      = 512;
  localparam logic [15:0] POOL_BASE      = 16'hfd80;
  localparam logic [15:0] POOL_LAST      = 16'hfeef;
  localparam logic [15:0] OUT_EP0_BUF    = 16'hfef0;
  localparam logic [15:0] IN_EP0_BUF     = 16'hfef8;
  localparam logic [15:0] SETUP_BLOCK    = 16'hff00;
  localparam logic [15:0] OUT_DESC_BASE  = 16'hff00;
  localparam logic [15:0] IN_DESC_BASE   = 16'hff40;
  localparam logic [15:0] BUF_SPACE_BASE = 16'hf800;
  localparam int          DESC_BYTES     = 8;
  // Endpoint descriptor byte offsets
  localparam logic [2:0] OFS_CONFIG      = 3'h0;
  localparam logic [2:0] OFS_X_BASE      = 3'h1;
  localparam logic [2:0] OFS_X_COUNT     = 3'h2;
  localparam logic [2:0] OFS_UNUSED_A    = 3'h3;
  localparam logic [2:0] OFS_UNUSED_B    = 3'h4;
  localparam logic [2:0] OFS_Y_BASE      = 3'h5;
  localparam logic [2:0] OFS_Y_COUNT     = 3'h6;
  localparam logic [2:0] OFS_XY_SIZE     = 3'h7;
  // Memory-mapped registers
  localparam logic [15:0] ADDR_IN_EP0_CONFIG  = 16'hff80;
  localparam logic [15:0] ADDR_IN_EP0_COUNT   = 16'hff81;
  localparam logic [15:0] ADDR_OUT_EP0_CONFIG = 16'hff82;
  localparam logic [15:0] ADDR_OUT_EP0_COUNT  = 16'hff83;
  localparam logic [15:0] ADDR_USB_CONTROL    = 16'hfffc;
  localparam logic [15:0] ADDR_USB_INT_MASK   = 16'hfffd;
  localparam logic [15:0] ADDR_USB_STATUS     = 16'hfffe;
  localparam logic [15:0] ADDR_FUNCTION_ADDR  = 16'hffff;
  // Configuration byte fields
  localparam int BIT_MANAGER_USE_ENABLE  = 7;
  localparam int BIT_ISOCHRONOUS         = 6;
  localparam int BIT_DATA_TOGGLE_STATE   = 5;
  localparam int BIT_DUAL_BUFFER_ENABLE  = 4;
  localparam int BIT_STALL               = 3;
  localparam int BIT_COMPLETION_INT_EN   = 2;
  // Byte count fields
  localparam int BIT_BUFFER_OWNED        = 7;
  localparam logic [6:0] COUNT_MAX       = 7'h40;
  // Reset values
  localparam logic [7:0] RESET_EP0_CONFIG = 8'h00;
  localparam logic [7:0] RESET_EP0_COUNT  = 8'h00;
  localparam logic [7:0] RESET_USB_REG    = 8'h00;
endpackage
